// File: design/aoc_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "aoc_cfg.svh"

// Contract
// - enabled loop estimates dc offset, subtracts clamped correction from each sample
// - four-bit code sets loop constant, 2**20 cycles doubling to code 11
// - loop updates estimate on every valid sample clock, applies correction on every sample clock
// - hold stops estimate updates, last estimate keeps being applied
// - after reset offset correction stays off until enabled
// - reset default is bypass path, raw data delayed ten cycles
// - three sleep modes: full chip, core only, driver tristate
// - full chip sleep powers all off, tristates, long wake time
// - core sleep keeps references on, short wake time
// - tristate bit or enable pin float drivers, short recovery
// - missing samples beyond threshold enter low power automatically
// - sample words taken across by the req/ack handshake go out with a forwarded clock, the words between them are dropped
// - format bit or format pin selects lvds or cmos
// - lvds pair carries even bit at falling, odd bit at rising
// - swing field programs lvds amplitude, default code at reset
// - separate data and clock drive doubling bits, single after reset
// - cmos drives each bit on own pin, stable at rising edge
module aoc_ctrl #(
	parameter int DATA_W             = 14,
	parameter int GLOBAL_WAKE_CYCLES =
		(`AOC_GLOBAL_WAKE_NS + `AOC_CLK_PERIOD_NS - 1) / `AOC_CLK_PERIOD_NS
) (
	input  wire logic              i_sys_clk,
	input  wire logic              i_reset,
	input  wire logic              i_link_clk,
	input  wire logic [DATA_W-1:0] i_sample,
	input  wire logic              i_sample_valid,
	input  wire logic              i_bypass_path_disable,
	input  wire logic              i_dc_correction_enable,
	input  wire logic [3:0]        i_dc_loop_time_constant,
	input  wire logic              i_dc_correction_hold,
	input  wire logic              i_full_chip_sleep,
	input  wire logic              i_core_sleep,
	input  wire logic              i_driver_tristate,
	input  wire logic              i_output_enable_pin,
	input  wire logic              i_cmos_select,
	input  wire logic              i_format_config_pin,
	input  wire logic [3:0]        i_lvds_swing,
	input  wire logic              i_data_drive_double,
	input  wire logic              i_clock_drive_double,
	output logic                   o_core_power_on,
	output logic                   o_reference_power_on,
	output logic                   o_low_power,
	output logic                   o_data_valid,
	output logic      [DATA_W-1:0] o_dc_estimate,
	output logic      [3:0]        o_lvds_swing,
	output logic                   o_data_drive_double,
	output logic                   o_clock_drive_double,
	output logic [DATA_W/2-1:0]    o_lvds_data,
	output logic      [DATA_W-1:0] o_cmos_data,
	output logic                   o_forwarded_clock,
	output logic                   o_out_oe
);

	localparam int PAIRS        = DATA_W / 2;
	localparam int ACC_W        = DATA_W + `AOC_TC_BASE_LOG2 + 13;
	localparam int CORE_SLEEP_CYCLES  =
		(`AOC_CORE_SLEEP_WAKE_NS + `AOC_CLK_PERIOD_NS - 1) / `AOC_CLK_PERIOD_NS;
	localparam int OBUF_CYCLES  =
		(`AOC_OBUF_WAKE_NS + `AOC_CLK_PERIOD_NS - 1) / `AOC_CLK_PERIOD_NS;
	localparam int STOP_CYCLES  = `AOC_CLK_STOP_NS / `AOC_CLK_PERIOD_NS;
	localparam logic signed [DATA_W-1:0] LIMIT = DATA_W'(`AOC_OFFSET_LIMIT);

	function automatic logic [DATA_W-1:0] flip_msb(input logic [DATA_W-1:0] w);
		flip_msb = {~w[DATA_W-1], w[DATA_W-2:0]};
	endfunction

	function automatic logic [PAIRS-1:0] pick_bits(input logic [DATA_W-1:0] w,
		input logic odd);
		logic [PAIRS-1:0] r;
		r = '0;
		for (int i = 0; i < PAIRS; i++) begin
			r[i] = w[2*i + (odd ? 1 : 0)];
		end
		pick_bits = r;
	endfunction

	// pin synchronisers
	logic oe_pin_m, oe_pin_s, fmt_pin_m, fmt_pin_s;

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			oe_pin_m  <= 1'b0;
			oe_pin_s  <= 1'b0;
			fmt_pin_m <= 1'b0;
			fmt_pin_s <= 1'b0;
		end else begin
			oe_pin_m  <= i_output_enable_pin;
			oe_pin_s  <= oe_pin_m;
			fmt_pin_m <= i_format_config_pin;
			fmt_pin_s <= fmt_pin_m;
		end
	end

	// driver settings
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_lvds_swing         <= `AOC_SWING_RESET;
			o_data_drive_double  <= 1'b0;
			o_clock_drive_double <= 1'b0;
		end else begin
			o_lvds_swing         <= i_lvds_swing;
			o_data_drive_double  <= i_data_drive_double;
			o_clock_drive_double <= i_clock_drive_double;
		end
	end

	// offset loop
	logic [3:0]                tc_active;
	logic signed [ACC_W-1:0]   acc;
	logic signed [ACC_W-1:0]   est_full;
	logic signed [ACC_W-1:0]   sx_ext;
	logic signed [DATA_W-1:0]  sx;
	logic signed [DATA_W-1:0]  est_clamped;
	logic signed [DATA_W:0]    diff;
	logic signed [DATA_W-1:0]  corrected;
	logic [4:0]                shift;
	logic                      loop_run;
	logic [DATA_W-1:0]         corr_word;

	assign loop_run = i_dc_correction_enable && i_bypass_path_disable;
	assign sx       = $signed(flip_msb(i_sample));
	assign sx_ext   = {{(ACC_W-DATA_W){sx[DATA_W-1]}}, sx};
	assign shift    = 5'(`AOC_TC_BASE_LOG2) + {1'b0, tc_active};
	assign est_full = acc >>> shift;

	always_comb begin
		if (est_full > ACC_W'(LIMIT)) begin
			est_clamped = LIMIT;
		end else if (est_full < -ACC_W'(LIMIT)) begin
			est_clamped = -LIMIT;
		end else begin
			est_clamped = est_full[DATA_W-1:0];
		end
		diff = {sx[DATA_W-1], sx} - {est_clamped[DATA_W-1], est_clamped};
		if (diff[DATA_W] != diff[DATA_W-1]) begin
			corrected = diff[DATA_W] ? {1'b1, {(DATA_W-1){1'b0}}}
				: {1'b0, {(DATA_W-1){1'b1}}};
		end else begin
			corrected = diff[DATA_W-1:0];
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			tc_active <= `AOC_TC_RESET;
		end else if (i_dc_loop_time_constant <= `AOC_TC_LAST_VALID) begin
			tc_active <= i_dc_loop_time_constant;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset || !loop_run) begin
			acc <= '0;
		end else if (i_sample_valid && !i_dc_correction_hold) begin
			acc <= acc + sx_ext - est_full;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			corr_word     <= '0;
			o_dc_estimate <= '0;
		end else begin
			corr_word     <= flip_msb(corrected);
			o_dc_estimate <= est_clamped;
		end
	end

	a_corr_inactive: assert property (@(posedge i_sys_clk) disable iff (i_reset) !i_dc_correction_enable |-> ##2 (o_dc_estimate == '0)) else $error("correction active while disabled");
	a_hold_keeps: assert property (@(posedge i_sys_clk) disable iff (i_reset) (loop_run && i_dc_correction_hold) |=> $stable(acc)) else $error("estimate moved while held");
	a_loop_updates: assert property (@(posedge i_sys_clk) disable iff (i_reset) (loop_run && !i_dc_correction_hold && i_sample_valid && sx_ext != est_full) |=> (acc != $past(acc))) else $error("loop did not update");
	a_estimate_bound: assert property (@(posedge i_sys_clk) disable iff (i_reset) ($signed(o_dc_estimate) <= LIMIT && $signed(o_dc_estimate) >= -LIMIT)) else $error("correction beyond range");
	a_tc_reserved: assert property (@(posedge i_sys_clk) disable iff (i_reset) (i_dc_loop_time_constant > `AOC_TC_LAST_VALID) |=> $stable(tc_active)) else $error("reserved constant taken");
	a_tc_valid: assert property (@(posedge i_sys_clk) disable iff (i_reset) (i_dc_loop_time_constant <= `AOC_TC_LAST_VALID) |=> (tc_active == $past(i_dc_loop_time_constant))) else $error("valid constant not taken");

	// data paths
	logic [DATA_W-1:0] bypass_out, digital_out, stream_word;

	aoc_delay_line #(.WIDTH(DATA_W), .DEPTH(`AOC_BYPASS_LATENCY)) u_bypass (
		.i_sys_clk (i_sys_clk),
		.i_reset   (i_reset),
		.i_data    (i_sample),
		.o_data    (bypass_out)
	);

	aoc_delay_line #(.WIDTH(DATA_W), .DEPTH(`AOC_DIGITAL_LATENCY - 1)) u_digital (
		.i_sys_clk (i_sys_clk),
		.i_reset   (i_reset),
		.i_data    (corr_word),
		.o_data    (digital_out)
	);

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			stream_word <= '0;
		end else begin
			stream_word <= i_bypass_path_disable ? digital_out : bypass_out;
		end
	end

	// power control
	aoc_pkg::aoc_power_type state, next_state;
	logic [15:0] wake_cnt;
	logic [7:0]  drv_cnt;
	logic [7:0]  gap_cnt;
	logic        drv_on, drive_en, cmos_sys;

	always_comb begin
		next_state = state;
		case (state)
			aoc_pkg::AOC_PWR_ACTIVE: begin
				if (i_full_chip_sleep) begin
					next_state = aoc_pkg::AOC_PWR_CHIP_OFF;
				end else if (i_core_sleep) begin
					next_state = aoc_pkg::AOC_PWR_CORE_OFF;
				end
			end
			aoc_pkg::AOC_PWR_CHIP_OFF: begin
				if (!i_full_chip_sleep) begin
					next_state = i_core_sleep ? aoc_pkg::AOC_PWR_CORE_OFF
						: aoc_pkg::AOC_PWR_WAKING;
				end
			end
			aoc_pkg::AOC_PWR_CORE_OFF: begin
				if (i_full_chip_sleep) begin
					next_state = aoc_pkg::AOC_PWR_CHIP_OFF;
				end else if (!i_core_sleep) begin
					next_state = aoc_pkg::AOC_PWR_WAKING;
				end
			end
			aoc_pkg::AOC_PWR_WAKING: begin
				if (i_full_chip_sleep) begin
					next_state = aoc_pkg::AOC_PWR_CHIP_OFF;
				end else if (i_core_sleep) begin
					next_state = aoc_pkg::AOC_PWR_CORE_OFF;
				end else if (wake_cnt <= 16'h0001) begin
					next_state = aoc_pkg::AOC_PWR_ACTIVE;
				end
			end
			default: begin
				next_state = aoc_pkg::AOC_PWR_ACTIVE;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			state <= aoc_pkg::AOC_PWR_ACTIVE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			wake_cnt <= 16'h0000;
		end else if (state == aoc_pkg::AOC_PWR_CHIP_OFF) begin
			wake_cnt <= 16'(GLOBAL_WAKE_CYCLES);
		end else if (state == aoc_pkg::AOC_PWR_CORE_OFF) begin
			wake_cnt <= 16'(CORE_SLEEP_CYCLES);
		end else if (wake_cnt != 16'h0000) begin
			wake_cnt <= wake_cnt - 16'h0001;
		end
	end

	assign drv_on = !i_full_chip_sleep && !i_driver_tristate && oe_pin_s;

	always_ff @(posedge i_sys_clk) begin
		if (i_reset || !drv_on) begin
			drv_cnt <= 8'(OBUF_CYCLES);
		end else if (drv_cnt != 8'h00) begin
			drv_cnt <= drv_cnt - 8'h01;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset || i_sample_valid) begin
			gap_cnt <= 8'h00;
		end else if (gap_cnt < 8'(STOP_CYCLES)) begin
			gap_cnt <= gap_cnt + 8'h01;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_low_power          <= 1'b0;
			o_core_power_on      <= 1'b1;
			o_reference_power_on <= 1'b1;
			o_data_valid         <= 1'b0;
			drive_en             <= 1'b0;
			cmos_sys             <= 1'b0;
		end else begin
			o_low_power          <= (gap_cnt >= 8'(STOP_CYCLES));
			o_core_power_on      <= (state == aoc_pkg::AOC_PWR_ACTIVE)
				|| (state == aoc_pkg::AOC_PWR_WAKING);
			o_reference_power_on <= (state != aoc_pkg::AOC_PWR_CHIP_OFF);
			o_data_valid         <= (state == aoc_pkg::AOC_PWR_ACTIVE) && drv_on
				&& (drv_cnt == 8'h00) && (gap_cnt < 8'(STOP_CYCLES));
			drive_en             <= drv_on;
			cmos_sys             <= i_cmos_select || fmt_pin_s;
		end
	end

	sequence s_chip_wake;
		(state == aoc_pkg::AOC_PWR_CHIP_OFF) ##1 (state == aoc_pkg::AOC_PWR_WAKING);
	endsequence
	sequence s_core_wake;
		(state == aoc_pkg::AOC_PWR_CORE_OFF) ##1 (state == aoc_pkg::AOC_PWR_WAKING);
	endsequence

	a_global_wake: assert property (@(posedge i_sys_clk) disable iff (i_reset) s_chip_wake |-> (wake_cnt == 16'(GLOBAL_WAKE_CYCLES)) && !o_data_valid) else $error("global wake time wrong");
	a_standby_wake: assert property (@(posedge i_sys_clk) disable iff (i_reset) s_core_wake |-> (wake_cnt == 16'(CORE_SLEEP_CYCLES)) ##1 o_reference_power_on) else $error("standby wake time wrong");
	a_tristate_off: assert property (@(posedge i_sys_clk) disable iff (i_reset) (i_driver_tristate || i_full_chip_sleep) |=> !drive_en ##1 !o_data_valid) else $error("drivers not floated");
	a_low_power: assert property (@(posedge i_sys_clk) disable iff (i_reset) i_sample_valid |-> ##2 !o_low_power) else $error("low power with samples");

	// crossing to link domain
	logic              req, ack_m, ack_s;
	logic [DATA_W-1:0] xfer_word;

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			req       <= 1'b0;
			xfer_word <= '0;
		end else if (req == ack_s) begin
			req       <= ~req;
			xfer_word <= stream_word;
		end
	end

	logic link_rst_m, link_rst;
	logic req_m, req_s, req_d, ack_l;
	logic oe_m, oe_s, cmos_m, cmos_l;
	logic phase;
	logic [DATA_W-1:0] word_l, shown;

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			ack_m <= 1'b0;
			ack_s <= 1'b0;
		end else begin
			ack_m <= ack_l;
			ack_s <= ack_m;
		end
	end

	always_ff @(posedge i_link_clk) begin
		link_rst_m <= i_reset;
		link_rst   <= link_rst_m;
	end

	always_ff @(posedge i_link_clk) begin
		if (link_rst) begin
			req_m  <= 1'b0;
			req_s  <= 1'b0;
			req_d  <= 1'b0;
			ack_l  <= 1'b0;
			oe_m   <= 1'b0;
			oe_s   <= 1'b0;
			cmos_m <= 1'b0;
			cmos_l <= 1'b0;
			word_l <= '0;
		end else begin
			req_m  <= req;
			req_s  <= req_m;
			req_d  <= req_s;
			ack_l  <= req_s;
			oe_m   <= drive_en;
			oe_s   <= oe_m;
			cmos_m <= cmos_sys;
			cmos_l <= cmos_m;
			if (req_s != req_d) begin
				word_l <= xfer_word;
			end
		end
	end

	// phase 1 leads into the falling half, phase 0 into the rising half
	always_ff @(posedge i_link_clk) begin
		if (link_rst) begin
			phase             <= 1'b0;
			shown             <= '0;
			o_forwarded_clock <= 1'b0;
			o_lvds_data       <= '0;
			o_cmos_data       <= '0;
			o_out_oe          <= 1'b0;
		end else begin
			phase    <= ~phase;
			o_out_oe <= oe_s;
			if (phase) begin
				shown             <= word_l;
				o_forwarded_clock <= 1'b0;
				o_lvds_data       <= (oe_s && !cmos_l) ? pick_bits(word_l, 1'b0) : '0;
				o_cmos_data       <= (oe_s && cmos_l) ? word_l : '0;
			end else begin
				o_forwarded_clock <= oe_s;
				o_lvds_data       <= (oe_s && !cmos_l) ? pick_bits(shown, 1'b1) : '0;
			end
		end
	end

	a_lvds_even_fall: assert property (@(posedge i_link_clk) disable iff (link_rst) (phase && oe_s && !cmos_l) |=> !o_forwarded_clock && (o_lvds_data == pick_bits($past(word_l), 1'b0))) else $error("even bits not at falling edge");
	a_lvds_odd_rise: assert property (@(posedge i_link_clk) disable iff (link_rst) (!phase && oe_s && !cmos_l) |=> (o_lvds_data == pick_bits($past(shown), 1'b1))) else $error("odd bits not at rising edge");
	a_cmos_stable: assert property (@(posedge i_link_clk) disable iff (link_rst) $rose(o_forwarded_clock) |-> $stable(o_cmos_data)) else $error("cmos data moved at rising edge");

endmodule

`default_nettype wire

// File: design/aoc_cfg.svh
`ifndef AOC_CFG_SVH
`define AOC_CFG_SVH

// timing, in nanoseconds, at the system clock period
`define AOC_CLK_PERIOD_NS     10
`define AOC_GLOBAL_WAKE_NS    100000
`define AOC_CORE_SLEEP_WAKE_NS      5000
`define AOC_OBUF_WAKE_NS      100
`define AOC_CLK_STOP_NS       1000

// pipeline depths in clock cycles
`define AOC_BYPASS_LATENCY    10
`define AOC_DIGITAL_LATENCY   14

// offset loop: code 0 is 2**20 cycles
`define AOC_TC_BASE_LOG2      20
`define AOC_TC_RESET          4'h0
`define AOC_TC_LAST_VALID     4'hB
`define AOC_OFFSET_LIMIT      82

// driver settings after reset
`define AOC_SWING_RESET       4'h0

`endif

// File: design/aoc_pkg.sv
`default_nettype none

package aoc_pkg;

	typedef enum logic [1:0] {
		AOC_PWR_ACTIVE   = 2'b00,
		AOC_PWR_CORE_OFF = 2'b01,
		AOC_PWR_CHIP_OFF = 2'b10,
		AOC_PWR_WAKING   = 2'b11
	} aoc_power_type;

endpackage

`default_nettype wire

// File: design/aoc_delay_line.sv
`timescale 1ns/1ns
`default_nettype none

module aoc_delay_line #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 10
) (
	input  wire logic             i_sys_clk,
	input  wire logic             i_reset,
	input  wire logic [WIDTH-1:0] i_data,
	output logic      [WIDTH-1:0] o_data
);

	logic [WIDTH-1:0] stage [DEPTH];
	logic [7:0]       fill;

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			for (int i = 0; i < DEPTH; i++) begin
				stage[i] <= '0;
			end
		end else begin
			stage[0] <= i_data;
			for (int i = 1; i < DEPTH; i++) begin
				stage[i] <= stage[i-1];
			end
		end
	end

	assign o_data = stage[DEPTH-1];

	// fill counter only for checking
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			fill <= 8'h00;
		end else if (fill < 8'(DEPTH)) begin
			fill <= fill + 8'h01;
		end
	end

	a_delay_exact: assert property (@(posedge i_sys_clk) disable iff (i_reset) (fill == 8'(DEPTH)) |-> (o_data == $past(i_data, DEPTH))) else $error("delay line depth wrong");

endmodule

`default_nettype wire

// File: testbench/aoc_rx_model.sv
`timescale 1ns/1ns
`default_nettype none

module aoc_rx_model #(
	parameter int DATA_W = 14
) (
	input  wire logic              i_link_clk,
	input  wire logic              i_cmos_mode,
	input  wire logic              i_fwd_clk,
	input  wire logic [DATA_W/2-1:0] i_lvds,
	input  wire logic [DATA_W-1:0] i_cmos,
	output logic      [DATA_W-1:0] o_word,
	output logic      [15:0]       o_count
);
	logic [DATA_W/2-1:0] even_bits;
	logic [DATA_W-1:0]   word;

	initial begin
		o_word = '0;
		o_count = '0;
		even_bits = '0;
		word = '0;
	end

	// reads the pins before this edge's updates land
	always @(posedge i_link_clk) begin
		if (i_fwd_clk === 1'b1) begin
			for (int i = 0; i < DATA_W/2; i++) begin
				word[2*i] = even_bits[i];
				word[2*i+1] = i_lvds[i];
			end
			o_word <= i_cmos_mode ? i_cmos : word;
			o_count <= o_count + 16'h0001;
		end else begin
			even_bits = i_lvds;
		end
	end
endmodule

`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none

module testbench;
	localparam int DW = 14;
	logic          clk;
	logic          link_clk;
	logic          rst;
	logic [DW-1:0] sample;
	logic          valid, byp_dis, en, hold, full_sl, core_sl, tri_s, oe_pin;
	logic          cmos_sel, fmt_pin, d_dbl, c_dbl;
	logic [3:0]    tc, swing;
	logic          core_on, ref_on, low_pwr, data_ok, fwd, oe_out, o_ddbl, o_cdbl;
	logic [DW-1:0] est, cmos_d, rx_word;
	logic [3:0]    o_swing;
	logic [DW/2-1:0] lvds_d;
	logic [15:0]   rx_cnt, cnt0;
	int            miscompares = 0;
	int            samples_checked = 0;
	int            n;

	aoc_ctrl #(.DATA_W(DW), .GLOBAL_WAKE_CYCLES(50)) dut_u (
		.i_sys_clk(clk), .i_reset(rst), .i_link_clk(link_clk), .i_sample(sample),
		.i_sample_valid(valid), .i_bypass_path_disable(byp_dis),
		.i_dc_correction_enable(en), .i_dc_loop_time_constant(tc),
		.i_dc_correction_hold(hold), .i_full_chip_sleep(full_sl), .i_core_sleep(core_sl),
		.i_driver_tristate(tri_s), .i_output_enable_pin(oe_pin), .i_cmos_select(cmos_sel),
		.i_format_config_pin(fmt_pin), .i_lvds_swing(swing), .i_data_drive_double(d_dbl),
		.i_clock_drive_double(c_dbl), .o_core_power_on(core_on),
		.o_reference_power_on(ref_on), .o_low_power(low_pwr), .o_data_valid(data_ok),
		.o_dc_estimate(est), .o_lvds_swing(o_swing), .o_data_drive_double(o_ddbl),
		.o_clock_drive_double(o_cdbl), .o_lvds_data(lvds_d), .o_cmos_data(cmos_d),
		.o_forwarded_clock(fwd), .o_out_oe(oe_out)
	);

	aoc_rx_model #(.DATA_W(DW)) rx_u (
		.i_link_clk(link_clk), .i_cmos_mode(cmos_sel | fmt_pin), .i_fwd_clk(fwd),
		.i_lvds(lvds_d), .i_cmos(cmos_d), .o_word(rx_word), .o_count(rx_cnt)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		link_clk = 1'b0;
		#7;
		forever #24 link_clk = ~link_clk;
	end

	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask

	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic test_done();
		$display("checked %0d mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// stream a word and look at what the receiver put together
	task automatic stream(input logic [DW-1:0] w, input logic pin);
		sample = w;
		fmt_pin = pin;
		cnt0 = rx_cnt;
		cyc(80);
		check("rx_word", 16'(w), 16'(rx_word));
		check("rx_moving", 16'h0001, 16'(rx_cnt != cnt0));
	endtask

	initial begin
		#500000;
		miscompares++;
		test_done();
	end

	initial begin
		rst = 1'b1; sample = '0; valid = 1'b1; byp_dis = 1'b0; en = 1'b0; hold = 1'b0;
		full_sl = 1'b0; core_sl = 1'b0; tri_s = 1'b0; oe_pin = 1'b1; cmos_sel = 1'b0;
		fmt_pin = 1'b0; d_dbl = 1'b0; c_dbl = 1'b0; tc = 4'h0; swing = 4'h0;
		cyc(6);
		check("swing_rst", 16'h0000, 16'(o_swing));
		check("ddbl_rst", 16'h0000, 16'(o_ddbl));
		check("cdbl_rst", 16'h0000, 16'(o_cdbl));
		rst = 1'b0;
		for (int k = 0; k < 2; k++) begin
			swing = k ? 4'h5 : 4'hA;
			d_dbl = k[0];
			c_dbl = !k[0];
			cyc(3);
			check("swing", 16'(swing), 16'(o_swing));
			check("ddbl", 16'(d_dbl), 16'(o_ddbl));
			check("cdbl", 16'(c_dbl), 16'(o_cdbl));
		end
		$display("test settings done");

		stream(14'h2A5C, 1'b0);
		stream(14'h1C3A, 1'b1);
		cmos_sel = 1'b1;
		stream(14'h15A3, 1'b0);
		cmos_sel = 1'b0;
		$display("test stream done");

		for (int k = 0; k < 2; k++) begin
			tri_s = (k == 0);
			oe_pin = (k == 0);
			cyc(20);
			check("oe_off", 16'h0000, 16'(oe_out));
			check("lvds_off", 16'h0000, 16'(lvds_d));
			check("valid_tri", 16'h0000, 16'(data_ok));
			cnt0 = rx_cnt;
			cyc(20);
			check("rx_stalled", 16'(cnt0), 16'(rx_cnt));
			tri_s = 1'b0;
			oe_pin = 1'b1;
			for (n = 0; n < 40 && oe_out !== 1'b1; n++) cyc(1);
			check("oe_back", 16'h0001, 16'(oe_out));
		end
		$display("test tristate done");

		for (int k = 0; k < 3; k++) begin
			full_sl = (k != 1);
			core_sl = (k != 0);
			cyc(4);
			check("ref_on", 16'(k == 1), 16'(ref_on));
			check("core_on", 16'h0000, 16'(core_on));
			check("valid_off", 16'h0000, 16'(data_ok));
			full_sl = 1'b0;
			core_sl = 1'b0;
			for (n = 0; n < 600 && data_ok !== 1'b1; n++) cyc(1);
			check("valid_back", 16'h0001, 16'(data_ok));
			check("wake_bound", 16'h0001, 16'(n < ((k == 1) ? 530 : 80)));
			check("wake_min", 16'h0001, 16'(n > ((k == 1) ? 480 : 40)));
		end
		$display("test power done");

		valid = 1'b0;
		cyc(60);
		check("lp_early", 16'h0000, 16'(low_pwr));
		cyc(60);
		check("lp_on", 16'h0001, 16'(low_pwr));
		valid = 1'b1;
		cyc(5);
		check("lp_off", 16'h0000, 16'(low_pwr));
		$display("test clock stop done");

		sample = 14'h3FFF;
		cyc(300);
		check("est_off", 16'h0000, 16'(est));
		byp_dis = 1'b1;
		cyc(5);
		for (int k = 0; k < 3; k++) begin
			en = 1'b0;
			tc = (k == 0) ? 4'h0 : 4'h1;
			cyc(4);
			tc = (k == 2) ? 4'hF : tc;
			en = 1'b1;
			cyc(1000);
			check("est", (k == 0) ? 16'h0007 : 16'h0003, 16'(est));
		end
		hold = 1'b1;
		cyc(300);
		check("est_held", 16'h0003, 16'(est));
		check("rx_corr", 16'h3FFC, 16'(rx_word));
		$display("test offset done");
		test_done();
	end
endmodule

`default_nettype wire
